// ### include/eiu_pkg.sv
package eiu_pkg;

  // ==========================================================================
  // Register addresses on the special function register port
  // ==========================================================================
  localparam logic [7:0] EIU_ADDR_STD_ENABLE = 8'ha8;
  localparam logic [7:0] EIU_ADDR_STD_LEVEL  = 8'hb8;
  localparam logic [7:0] EIU_ADDR_EXT_FLAG   = 8'h91;
  localparam logic [7:0] EIU_ADDR_WAKE_FLAG  = 8'hd8;
  localparam logic [7:0] EIU_ADDR_EXT_ENABLE = 8'he8;
  localparam logic [7:0] EIU_ADDR_EXT_LEVEL  = 8'hf8;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int EIU_GLOBAL_GATE_BIT  = 7;
  localparam int EIU_ADC_FLAG_BIT     = 4;
  localparam int EIU_SPI_FLAG_BIT     = 5;
  localparam int EIU_RADIO1_FLAG_BIT  = 6;
  localparam int EIU_RADIO2_FLAG_BIT  = 7;
  localparam int EIU_WAKE_FLAG_BIT    = 3;
  localparam int EIU_NUM_STD          = 6;
  localparam int EIU_NUM_EXT          = 5;
  localparam int EIU_NUM_SRC          = 11;

  // Source index equals natural rank order: 0..5 standard, then
  // adc, spi, radio one, radio two, wakeup tick.
  localparam logic [3:0] EIU_IDX_ADC  = 4'h6;
  localparam logic [3:0] EIU_IDX_WAKE = 4'ha;

  // ==========================================================================
  // Reserved bit read values and reset values
  // ==========================================================================
  localparam logic [7:0] EIU_EXT_FLAG_FIXED  = 8'h08;
  localparam logic [7:0] EIU_WAKE_FLAG_FIXED = 8'h40;
  localparam logic [7:0] EIU_EXT_CTRL_FIXED  = 8'he0;
  localparam logic [7:0] EIU_STD_LEVEL_FIXED = 8'h80;
  localparam logic [5:0] EIU_STD_RESET       = 6'h00;
  localparam logic [4:0] EIU_EXT_RESET       = 5'h00;
  localparam logic [7:0] EIU_RDATA_RESET     = 8'h00;

  // ==========================================================================
  // Vector table, entry 10 first
  // ==========================================================================
  localparam logic [10:0][7:0] EIU_VECTORS = {
    8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43,
    8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03
  };

endpackage : eiu_pkg

// ### hdl/eiu_ext_irq_unit.sv
`timescale 1ns/1ps
module eiu_ext_irq_unit
  import eiu_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic       SFR_WR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_RD_I,
  output logic      [7:0] SFR_RDATA_O,
  input  wire logic [5:0] STD_REQ_I,
  input  wire logic       ADC_CONV_DONE_I,
  input  wire logic       SPI_BYTE_DONE_I,
  input  wire logic       RADIO_DATA_READY_ONE_I,
  input  wire logic       RADIO_DATA_READY_TWO_I,
  input  wire logic       WAKE_TICK_I,
  input  wire logic       INSTR_END_I,
  input  wire logic       INSTR_RETI_I,
  output logic            IRQ_TAKE_O,
  output logic      [7:0] IRQ_VECTOR_O,
  output logic            IRQ_LEVEL_O,
  output logic      [1:0] IN_SERVICE_O
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [3:0] first_idx(input logic [10:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = EIU_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_idx

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic       global_gate_q;
  logic [5:0] std_enable_q;
  logic [5:0] std_level_q;
  logic [4:0] ext_enable_q;
  logic [4:0] ext_level_q;
  logic       adc_done_flag_q;
  logic       spi_done_flag_q;
  logic       radio_dr_one_flag_q;
  logic       radio_dr_two_flag_q;
  logic       wake_flag_q;
  logic       adc_prev_q;
  logic       radio_one_prev_q;
  logic       radio_two_prev_q;
  logic       skip_q;
  logic       in_low_q;
  logic       in_high_q;

  logic       wr_flag;
  logic       wr_wake;
  logic       ctl_wr;
  logic       adc_rise;
  logic       radio_one_rise;
  logic       radio_two_rise;

  assign wr_flag        = SFR_WR_I && (SFR_ADDR_I == EIU_ADDR_EXT_FLAG);
  assign wr_wake        = SFR_WR_I && (SFR_ADDR_I == EIU_ADDR_WAKE_FLAG);
  assign ctl_wr         = SFR_WR_I && ((SFR_ADDR_I == EIU_ADDR_STD_ENABLE) ||
                          (SFR_ADDR_I == EIU_ADDR_STD_LEVEL) ||
                          (SFR_ADDR_I == EIU_ADDR_EXT_ENABLE) ||
                          (SFR_ADDR_I == EIU_ADDR_EXT_LEVEL));
  assign adc_rise       = ADC_CONV_DONE_I && !adc_prev_q;
  assign radio_one_rise = RADIO_DATA_READY_ONE_I && !radio_one_prev_q;
  assign radio_two_rise = RADIO_DATA_READY_TWO_I && !radio_two_prev_q;

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      global_gate_q <= 1'b0;
      std_enable_q  <= EIU_STD_RESET;
      std_level_q   <= EIU_STD_RESET;
      ext_enable_q  <= EIU_EXT_RESET;
      ext_level_q   <= EIU_EXT_RESET;
    end else if (SFR_WR_I) begin
      case (SFR_ADDR_I)
        EIU_ADDR_STD_ENABLE: begin
          global_gate_q <= SFR_WDATA_I[EIU_GLOBAL_GATE_BIT];
          std_enable_q  <= SFR_WDATA_I[5:0];
        end
        EIU_ADDR_STD_LEVEL: begin
          std_level_q <= SFR_WDATA_I[5:0];
        end
        EIU_ADDR_EXT_ENABLE: begin
          ext_enable_q <= SFR_WDATA_I[4:0];
        end
        EIU_ADDR_EXT_LEVEL: begin
          ext_level_q <= SFR_WDATA_I[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Edge detectors
  // ==========================================================================
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      adc_prev_q       <= 1'b0;
      radio_one_prev_q <= 1'b0;
      radio_two_prev_q <= 1'b0;
    end else begin
      adc_prev_q       <= ADC_CONV_DONE_I;
      radio_one_prev_q <= RADIO_DATA_READY_ONE_I;
      radio_two_prev_q <= RADIO_DATA_READY_TWO_I;
    end
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  // A hardware event in the same cycle as a software clear wins, so no
  // event is lost; software write of one sets the flag like an event.
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      adc_done_flag_q     <= 1'b0;
      spi_done_flag_q     <= 1'b0;
      radio_dr_one_flag_q <= 1'b0;
      radio_dr_two_flag_q <= 1'b0;
    end else begin
      adc_done_flag_q <= (wr_flag ? SFR_WDATA_I[EIU_ADC_FLAG_BIT]
                          : adc_done_flag_q) | adc_rise;
      spi_done_flag_q <= (wr_flag ? SFR_WDATA_I[EIU_SPI_FLAG_BIT]
                          : spi_done_flag_q) | SPI_BYTE_DONE_I;
      radio_dr_one_flag_q <= (wr_flag ? SFR_WDATA_I[EIU_RADIO1_FLAG_BIT]
                              : radio_dr_one_flag_q) | radio_one_rise;
      radio_dr_two_flag_q <= (wr_flag ? SFR_WDATA_I[EIU_RADIO2_FLAG_BIT]
                              : radio_dr_two_flag_q) | radio_two_rise;
    end
  end

  // Wake flag is a level: left set, it re-requests after the routine ends
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wake_flag_q <= 1'b0;
    end else begin
      wake_flag_q <= (wr_wake ? SFR_WDATA_I[EIU_WAKE_FLAG_BIT]
                      : wake_flag_q) | WAKE_TICK_I;
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SFR_RDATA_O <= EIU_RDATA_RESET;
    end else if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        EIU_ADDR_STD_ENABLE: begin
          SFR_RDATA_O <= {global_gate_q, 1'b0, std_enable_q};
        end
        EIU_ADDR_STD_LEVEL: begin
          SFR_RDATA_O <= EIU_STD_LEVEL_FIXED | {2'b00, std_level_q};
        end
        EIU_ADDR_EXT_FLAG: begin
          SFR_RDATA_O <= EIU_EXT_FLAG_FIXED | {radio_dr_two_flag_q,
                         radio_dr_one_flag_q, spi_done_flag_q,
                         adc_done_flag_q, 4'h0};
        end
        EIU_ADDR_WAKE_FLAG: begin
          SFR_RDATA_O <= EIU_WAKE_FLAG_FIXED |
                         {4'h0, wake_flag_q, 3'b000};
        end
        EIU_ADDR_EXT_ENABLE: begin
          SFR_RDATA_O <= EIU_EXT_CTRL_FIXED | {3'b000, ext_enable_q};
        end
        EIU_ADDR_EXT_LEVEL: begin
          SFR_RDATA_O <= EIU_EXT_CTRL_FIXED | {3'b000, ext_level_q};
        end
        default: begin
          SFR_RDATA_O <= EIU_RDATA_RESET;
        end
      endcase
    end
  end

  // ==========================================================================
  // Arbitration
  // ==========================================================================
  logic [10:0] src_flag;
  logic [10:0] src_en;
  logic [10:0] src_lvl;
  logic [10:0] req;
  logic [10:0] hi_cand;
  logic [10:0] lo_cand;
  logic        win_high;
  logic        win_any;
  logic [3:0]  win_idx;
  logic        take_ok;

  assign src_flag = {wake_flag_q, radio_dr_two_flag_q, radio_dr_one_flag_q,
                     spi_done_flag_q, adc_done_flag_q, STD_REQ_I};
  assign src_en   = {ext_enable_q, std_enable_q};
  assign src_lvl  = {ext_level_q, std_level_q};
  assign req      = src_flag & src_en & {EIU_NUM_SRC{global_gate_q}};
  // A running high routine blocks all; a low one blocks only its own level
  assign hi_cand  = req & src_lvl & {EIU_NUM_SRC{!in_high_q}};
  assign lo_cand  = req & ~src_lvl &
                    {EIU_NUM_SRC{!in_high_q && !in_low_q}};
  assign win_high = |hi_cand;
  assign win_any  = win_high || (|lo_cand);
  assign win_idx  = win_high ? first_idx(hi_cand)
                             : first_idx(lo_cand);

  // Taken only at an instruction boundary, and never right after a return
  // or a write that changes enables or levels
  assign take_ok    = INSTR_END_I && !INSTR_RETI_I &&
                      !skip_q && !ctl_wr;
  assign IRQ_TAKE_O = take_ok && win_any;

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      skip_q <= 1'b0;
    end else if (INSTR_END_I) begin
      skip_q <= 1'b0;
    end else if (ctl_wr) begin
      skip_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Vector and service level tracking
  // ==========================================================================
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_VECTOR_O <= 8'h00;
      IRQ_LEVEL_O  <= 1'b0;
    end else if (IRQ_TAKE_O) begin
      IRQ_VECTOR_O <= EIU_VECTORS[win_idx];
      IRQ_LEVEL_O  <= win_high;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      in_low_q  <= 1'b0;
      in_high_q <= 1'b0;
    end else if (IRQ_TAKE_O) begin
      if (win_high) begin
        in_high_q <= 1'b1;
      end else begin
        in_low_q <= 1'b1;
      end
    end else if (INSTR_END_I && INSTR_RETI_I) begin
      // Return pops the innermost level; the core restores its own PC
      if (in_high_q) begin
        in_high_q <= 1'b0;
      end else begin
        in_low_q <= 1'b0;
      end
    end
  end

  assign IN_SERVICE_O = {in_high_q, in_low_q};

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_adc_edge_set: assert property (
    ADC_CONV_DONE_I && !adc_prev_q |=> adc_done_flag_q)
    else $error("adc edge did not set its flag");

  chk_spi_done_set: assert property (
    SPI_BYTE_DONE_I |=> spi_done_flag_q)
    else $error("spi byte done did not set its flag");

  chk_flag_sticky: assert property (
    adc_done_flag_q && !wr_flag |=> adc_done_flag_q)
    else $error("adc flag cleared without software");

  chk_radio_edge_set: assert property (
    RADIO_DATA_READY_TWO_I && !radio_two_prev_q |=> radio_dr_two_flag_q)
    else $error("radio ready edge did not set its flag");

  chk_rsv_flag_read: assert property (
    SFR_RD_I && SFR_ADDR_I == EIU_ADDR_EXT_FLAG |=> SFR_RDATA_O[3:0] == 4'h8)
    else $error("reserved flag bits read wrong");

  chk_rsv_ctrl_read: assert property (
    SFR_RD_I && (SFR_ADDR_I == EIU_ADDR_EXT_LEVEL ||
    SFR_ADDR_I == EIU_ADDR_WAKE_FLAG) |=> SFR_RDATA_O[7:5] ==
    ($past(SFR_ADDR_I) == EIU_ADDR_WAKE_FLAG ? 3'b010 : 3'b111))
    else $error("reserved upper bits read wrong");

  chk_wake_persist: assert property (
    WAKE_TICK_I ##1 (!wr_wake)[*2] |=> wake_flag_q)
    else $error("wake flag lost without software clear");

  chk_wake_sw_set: assert property (
    wr_wake && SFR_WDATA_I[3] |=> wake_flag_q && req[EIU_IDX_WAKE] ==
    (ext_enable_q[4] && global_gate_q))
    else $error("software wake set not requested");

  chk_gate_masks: assert property (
    !global_gate_q |-> !IRQ_TAKE_O)
    else $error("interrupt taken with global gate closed");

  chk_take_enabled: assert property (
    IRQ_TAKE_O |-> src_en[win_idx] && src_flag[win_idx])
    else $error("masked source taken");

  chk_vector_value: assert property (
    IRQ_TAKE_O && win_idx == EIU_IDX_ADC |=> IRQ_VECTOR_O == 8'h43)
    else $error("adc vector wrong");

  chk_rank_order: assert property (
    IRQ_TAKE_O && !win_high && lo_cand[5] && lo_cand[4:0] == 5'h00
    |=> IRQ_VECTOR_O == 8'h2b)
    else $error("natural rank not honoured");

  chk_level_first: assert property (
    IRQ_TAKE_O && (|hi_cand) |=> IRQ_LEVEL_O)
    else $error("low level won over high level");

  chk_preempt_level: assert property (
    IRQ_TAKE_O && IN_SERVICE_O != 2'b00 |-> win_high && !in_high_q)
    else $error("preempted by same or lower level");

  chk_boundary_only: assert property (
    IRQ_TAKE_O |-> INSTR_END_I)
    else $error("taken inside an instruction");

  chk_extra_instr: assert property (
    INSTR_END_I && INSTR_RETI_I |-> !IRQ_TAKE_O)
    else $error("taken directly after return");

  chk_reti_pop: assert property (
    INSTR_END_I && INSTR_RETI_I && in_high_q |=> !in_high_q)
    else $error("return did not end high routine");

endmodule : eiu_ext_irq_unit

// ### dv/eiu_cpu_model.sv
`timescale 1ns/1ps
// ============================================================================
// CPU side: runs one instruction of a set length when told, ends it with a
// one-cycle end pulse and records whether the unit took an interrupt there
// ============================================================================
module eiu_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       reti_i,
  input  wire logic [3:0] len_i,
  input  wire logic       irq_take_i,
  output logic            instr_end_o,
  output logic            instr_reti_o,
  output logic            busy_o,
  output logic            took_o
);
  logic [3:0] cnt_q;
  logic       reti_q;
  logic       took_q;

  assign busy_o       = (cnt_q != 4'h0);
  // End only on the last cycle, never in mid-instruction
  assign instr_end_o  = (cnt_q == 4'h1);
  // Qualifier toggles outside an end so nobody can lean on it
  assign instr_reti_o = instr_end_o ? reti_q : cnt_q[0];
  assign took_o       = took_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 4'h0;
      reti_q <= 1'b0;
    end else if (go_i) begin
      cnt_q  <= len_i;
      reti_q <= reti_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      took_q <= 1'b0;
    end else if (go_i) begin
      took_q <= 1'b0;
    end else if (instr_end_o) begin
      took_q <= irq_take_i;
    end
  end
endmodule : eiu_cpu_model

// ### dv/eiu_ext_irq_unit_tb.sv
`timescale 1ns/1ps
module eiu_ext_irq_unit_tb
  import eiu_pkg::*;
;
  logic       clk, rst, wr_s, rd_s, adc, spi, r1, r2, wake;
  logic       iend, ireti, go, reti_r, took, busy, take, lvl;
  logic [7:0] addr, wdata, rdata, vec;
  logic [5:0] std;
  logic [1:0] ins;
  int         bad_count, check_count, k;
  logic [7:0] ra [7] = '{8'h91, 8'hd8, 8'he8, 8'hf8, 8'ha8, 8'hb8, 8'h00};
  logic [7:0] rv [7] = '{8'h08, 8'h40, 8'he0, 8'he0, 8'h00, 8'h80, 8'h00};
  logic [7:0] wa [6] = '{8'he8, 8'hf8, 8'h91, 8'hd8, 8'hb8, 8'ha8};
  logic [7:0] wh [6] = '{8'hff, 8'hff, 8'hf8, 8'h48, 8'hbf, 8'hbf};
  logic [7:0] wl [6] = '{8'he0, 8'he0, 8'h08, 8'h40, 8'h80, 8'h00};
  logic [7:0] vt [6] = '{8'h2b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
  logic [7:0] ca [5] = '{8'h91, 8'h91, 8'h91, 8'h91, 8'hd8};
  logic [7:0] cd [5] = '{8'he0, 8'hc0, 8'h80, 8'h00, 8'h00};

  eiu_ext_irq_unit u_dut (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr_s),
    .SFR_WDATA_I(wdata), .SFR_RD_I(rd_s), .SFR_RDATA_O(rdata),
    .STD_REQ_I(std), .ADC_CONV_DONE_I(adc), .SPI_BYTE_DONE_I(spi),
    .RADIO_DATA_READY_ONE_I(r1), .RADIO_DATA_READY_TWO_I(r2),
    .WAKE_TICK_I(wake), .INSTR_END_I(iend), .INSTR_RETI_I(ireti),
    .IRQ_TAKE_O(take), .IRQ_VECTOR_O(vec), .IRQ_LEVEL_O(lvl),
    .IN_SERVICE_O(ins));

  eiu_cpu_model u_cpu (
    .clk_i(clk), .rst_i(rst), .go_i(go), .reti_i(reti_r), .len_i(4'h4),
    .irq_take_i(take), .instr_end_o(iend), .instr_reti_o(ireti),
    .busy_o(busy), .took_o(took));

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    addr = a; wdata = d; wr_s = 1'b1;
    @(posedge clk); #1;
    wr_s = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); #1;
    addr = a; rd_s = 1'b1;
    @(posedge clk); #1;
    rd_s = 1'b0;
    cmp(rdata, exp);
  endtask : reg_rd

  // One instruction; t says whether its end must take the interrupt
  task automatic run(input logic r, input logic t, input logic [7:0] v,
                     input logic l);
    int n;
    n = 0;
    @(posedge clk); #1;
    go = 1'b1; reti_r = r;
    @(posedge clk); #1;
    go = 1'b0;
    while (busy && n < 40) begin
      @(posedge clk); #1;
      n++;
    end
    cmp({7'h0, took}, {7'h0, t});
    if (t) begin
      cmp(vec, v);
      cmp({7'h0, lvl}, {7'h0, l});
    end
  endtask : run

  // ==========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  // ==========================================================================
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 0; rst = 1; wr_s = 0; rd_s = 0; addr = 0; wdata = 0; std = 0;
    adc = 0; spi = 0; r1 = 0; r2 = 0; wake = 0; go = 0; reti_r = 0;
    bad_count = 0; check_count = 0;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    for (k = 0; k < 7; k++) reg_rd(ra[k], rv[k]);
    for (k = 0; k < 6; k++) begin
      reg_wr(wa[k], 8'hff);
      reg_rd(wa[k], wh[k]);
      reg_wr(wa[k], 8'h00);
      reg_rd(wa[k], wl[k]);
    end
    @(posedge clk); #1;
    adc = 1; spi = 1; r1 = 1; r2 = 1; wake = 1;
    @(posedge clk); #1;
    spi = 0; wake = 0;
    repeat (4) @(posedge clk);
    reg_rd(8'h91, 8'hf8);
    reg_rd(8'hd8, 8'h48);
    adc = 0; r1 = 0; r2 = 0;
    reg_wr(8'ha8, 8'h80);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    reg_wr(8'he8, 8'h1f);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    reg_wr(8'ha8, 8'h00);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    std = 6'h20;
    reg_wr(8'ha8, 8'ha0);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    // Six sources pending at once; each pass takes the best and retires it
    for (k = 0; k < 6; k++) begin
      run(1'b0, 1'b1, vt[k], 1'b0);
      if (k == 0) begin
        std = 6'h00;
      end else begin
        reg_wr(ca[k-1], cd[k-1]);
      end
      run(1'b0, 1'b0, 8'h00, 1'b0);
      run(1'b1, 1'b0, 8'h00, 1'b0);
    end
    cmp({6'h0, ins}, 8'h00);
    reg_wr(8'hf8, 8'h10);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    adc = 1;
    run(1'b0, 1'b1, 8'h43, 1'b0);
    reg_wr(8'hd8, 8'h08);
    run(1'b0, 1'b1, 8'h63, 1'b1);
    cmp({6'h0, ins}, 8'h03);
    run(1'b0, 1'b0, 8'h00, 1'b0);
    run(1'b1, 1'b0, 8'h00, 1'b0);
    cmp({6'h0, ins}, 8'h01);
    run(1'b0, 1'b1, 8'h63, 1'b1);
    reg_wr(8'hd8, 8'h00);
    reg_wr(8'h91, 8'h00);
    run(1'b1, 1'b0, 8'h00, 1'b0);
    run(1'b1, 1'b0, 8'h00, 1'b0);
    cmp({6'h0, ins}, 8'h00);
    reg_wr(8'h91, 8'h10);
    reg_wr(8'hd8, 8'h08);
    run(1'b0, 1'b1, 8'h63, 1'b1);
    finish_test();
  end
endmodule : eiu_ext_irq_unit_tb
